// ---- rtl/cni_pkg.sv ----
// Constants and types shared by the network identity block
package cni_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int CLAIM_WAIT_US = 250000;
  localparam int CLAIM_WAIT_CYC = CLAIM_WAIT_US * CLK_MHZ;

  // ****************************************************************
  // Addresses and identifiers
  // ****************************************************************
  localparam logic [7:0] SA_DEFAULT = 8'h80;
  localparam logic [7:0] SA_MAX = 8'hfd;
  localparam logic [7:0] SA_NULL = 8'hfe;
  localparam logic [7:0] DA_GLOBAL = 8'hff;
  localparam logic [2:0] PRIO_DEFAULT = 3'h6;
  localparam logic [1:0] PAGE_ZERO = 2'h0;
  localparam logic [7:0] PF_ADDR_CLAIM = 8'hee;
  localparam logic [7:0] PF_REQUEST = 8'hea;
  localparam logic [7:0] PF_MAP_RESP = 8'hd8;
  localparam logic [7:0] PF_SOFT_ID = 8'hfe;
  localparam logic [7:0] PS_SOFT_ID = 8'hda;
  localparam logic [23:0] PGN_SOFT_ID = 24'h00feda;
  localparam logic [23:0] PGN_ADDR_CLAIM = 24'h00ee00;
  localparam logic [3:0] DLC_REQUEST = 4'h3;
  localparam logic [3:0] DLC_FULL = 4'h8;

  // ****************************************************************
  // Identity field defaults and positions
  // ****************************************************************
  localparam logic NAME_AAC = 1'b1;
  localparam logic [2:0] NAME_IND_GROUP = 3'h0;
  localparam logic [3:0] NAME_VS_INST = 4'h0;
  localparam logic [6:0] NAME_VSYS = 7'h00;
  localparam logic NAME_RSVD = 1'b0;
  localparam logic [4:0] NAME_FUNC_INST = 5'h01;
  localparam logic [2:0] ECU_INST_DEFAULT = 3'h0;
  localparam int NAME_ID_MSB = 20;
  localparam int NAME_ECU_LSB = 32;
  localparam int NAME_ECU_MSB = 34;
  localparam int NAME_AAC_BIT = 63;

  // ****************************************************************
  // Configuration space and payload bytes
  // ****************************************************************
  localparam logic [7:0] CFG_SA = 8'h00;
  localparam logic [7:0] CFG_ECU_INST = 8'h01;
  localparam logic [7:0] CFG_APP_PGN = 8'h02;
  localparam logic [7:0] CFG_STATUS = 8'h03;
  localparam logic [7:0] CFG_NAME_LO = 8'h04;
  localparam logic [7:0] CFG_NAME_HI = 8'h05;
  localparam logic [7:0] MAP_OK = 8'h00;
  localparam logic [7:0] MAP_ERR = 8'h01;
  localparam logic [7:0] SOFT_FIELDS = 8'h01;
  localparam logic [7:0] ASCII_STAR = 8'h2a;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam int PEND_CANNOT = 0;
  localparam int PEND_CLAIM = 1;
  localparam int PEND_RESP = 2;
  localparam int PEND_SOFT = 3;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_SEND = 3'b001,
    ST_WAIT = 3'b011,
    ST_OK = 3'b010,
    ST_LOST = 3'b110
  } cni_state_t;

endpackage

// ---- rtl/cni_tx_if.sv ----
// Send requests from the identity controller to the frame builder
`timescale 1ns/1ps
`default_nettype none
interface cni_tx_if;
  logic req_claim;
  logic req_cannot;
  logic req_soft;
  logic req_resp;
  logic [7:0] sa;
  logic [7:0] resp_dest;
  logic [7:0] resp_status;
  logic [7:0] resp_addr;
  logic [31:0] resp_value;
  logic claim_sent;
  modport ctrl (output req_claim, req_cannot, req_soft, req_resp, sa, resp_dest,
    resp_status, resp_addr, resp_value, input claim_sent);
  modport frm (input req_claim, req_cannot, req_soft, req_resp, sa, resp_dest,
    resp_status, resp_addr, resp_value, output claim_sent);
endinterface
`default_nettype wire

// ---- rtl/cni_tx_framer.sv ----
// Frame builder: queues send requests and presents one frame at a time
`timescale 1ns/1ps
`default_nettype none
module cni_tx_framer
  import cni_pkg::*;
#(
  parameter int VER_LEN = 4,
  parameter logic [8*VER_LEN-1:0] VERSION = 32'h312e3030
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requests
  cni_tx_if.frm tq,
  // Frame out
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [28:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data
);

  function automatic logic [63:0] soft_payload();
    logic [63:0] d;
    d = {8{FILL_BYTE}};
    d[7:0] = SOFT_FIELDS;
    for (int i = 0; i < VER_LEN; i++)
    begin
      d[8*(i+1) +: 8] = VERSION[8*(VER_LEN-1-i) +: 8];
    end
    d[8*(VER_LEN+1) +: 8] = ASCII_STAR;
    return d;
  endfunction

  logic [3:0] pend;
  logic [7:0] r_dest;
  logic [7:0] r_status;
  logic [7:0] r_addr;
  logic [31:0] r_value;

  // Lowest bit is most urgent: giving up outranks a claim
  wire [3:0] req_set = {tq.req_soft, tq.req_resp, tq.req_claim, tq.req_cannot};
  wire [3:0] pick = pend & ~(pend - 4'h1);
  wire [3:0] take = tx_valid ? 4'h0 : pick;
  wire [3:0] drop_claim = {2'b00, tq.req_cannot, 1'b0};
  // Set wins over the clear made by taking a request
  wire [3:0] next_pend = ((pend & ~take) | req_set) & ~drop_claim;
  wire [28:0] id_claim = {PRIO_DEFAULT, PAGE_ZERO, PF_ADDR_CLAIM, DA_GLOBAL, tq.sa};
  wire [28:0] id_cannot = {PRIO_DEFAULT, PAGE_ZERO, PF_ADDR_CLAIM, DA_GLOBAL, SA_NULL};
  wire [28:0] id_resp = {PRIO_DEFAULT, PAGE_ZERO, PF_MAP_RESP, r_dest, tq.sa}; // [RQ13]
  wire [28:0] id_soft = {PRIO_DEFAULT, PAGE_ZERO, PF_SOFT_ID, PS_SOFT_ID, tq.sa}; // [RQ8]
  wire [63:0] data_resp = {r_value, FILL_BYTE, FILL_BYTE, r_addr, r_status};
  wire [63:0] data_soft = soft_payload(); // [RQ9]
  wire [3:0] dlc_soft = 4'(VER_LEN + 2);
  wire take_claimish = take[PEND_CANNOT] | take[PEND_CLAIM];
  wire [28:0] next_id = take[PEND_CANNOT] ? id_cannot :
    take[PEND_CLAIM] ? id_claim : take[PEND_RESP] ? id_resp : id_soft;
  wire [63:0] next_data = take_claimish ? '0 : take[PEND_RESP] ? data_resp : data_soft;
  wire [3:0] next_dlc = (take_claimish | take[PEND_RESP]) ? DLC_FULL : dlc_soft;
  wire claim_done = tx_valid && tx_ready && tx_id[23:16] == PF_ADDR_CLAIM
    && tx_id[7:0] != SA_NULL;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend <= 4'h0;
      tq.claim_sent <= 1'b0;
    end
    else
    begin
      pend <= next_pend;
      tq.claim_sent <= claim_done;
    end
  end

  // Only the newest answer is kept while one waits for the bus
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r_dest <= 8'h00;
      r_status <= 8'h00;
      r_addr <= 8'h00;
      r_value <= 32'h0;
    end
    else if (tq.req_resp)
    begin
      r_dest <= tq.resp_dest;
      r_status <= tq.resp_status;
      r_addr <= tq.resp_addr;
      r_value <= tq.resp_value;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_valid <= 1'b0;
      tx_id <= 29'h0;
      tx_dlc <= 4'h0;
      tx_data <= 64'h0;
    end
    else if (tx_valid && tx_ready)
    begin
      tx_valid <= 1'b0;
    end
    else if (|take)
    begin
      tx_valid <= 1'b1;
      tx_id <= next_id;
      tx_dlc <= next_dlc;
      tx_data <= next_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  soft_payload_a: assert property (tx_valid && tx_id[23:8] == {PF_SOFT_ID, PS_SOFT_ID}
    |-> tx_data[7:0] == 8'h01 && tx_data[8*(VER_LEN+1) +: 8] == 8'h2a) // [RQ9]
    else $error("software id payload malformed");
  frame_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id)) // [RQ13]
    else $error("frame changed before it was taken");

endmodule
`default_nettype wire

// ---- rtl/cni_identity.sv ----
// Network identity, address contention and configuration space of the node
// ****************************************************************
// Notes on behaviour
// RQ1: Claim address at power-up and on change
// RQ2: Identity defaults: arbitrary capable, groups zero
// RQ3: Identity number captured from factory value
// RQ4: ECU instance field is configurable
// RQ5: Preferred source address defaults to 0x80
// RQ6: Source address accepted only from 0 to 253
// RQ7: Lost contention moves to next address, retries
// RQ8: Software identification sent only on request
// RQ9: Payload: count byte 1, version, asterisk
// RQ10: Configuration only through private memory access space
// RQ11: Application groups disabled by default
// RQ12: Configuring party uses memory access requests
// RQ13: Every memory access answered with response; an answer still waiting for the bus is lost to a newer one
// RQ14: No address left: cannot-claim, traffic stops
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module cni_identity
  import cni_pkg::*;
#(
  parameter int CLAIM_WAIT = CLAIM_WAIT_CYC,
  parameter int APP_PGN_N = 8,
  parameter int VER_LEN = 4,
  parameter logic [8*VER_LEN-1:0] VERSION = 32'h312e3030,
  // Arbitrary value
  parameter logic [10:0] MAKER_CODE = 11'h001,
  // Arbitrary value
  parameter logic [7:0] FUNCTION_CODE = 8'h55
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Factory programmed identity
  input wire logic [20:0] factory_identity,
  // Memory access configuration port
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_src,
  output logic [31:0] cfg_rdata,
  // Received frames
  input wire logic rx_valid,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  // Transmitted frames
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [28:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  // Node status
  output logic app_traffic_en,
  output logic [APP_PGN_N-1:0] app_pgn_en
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int TW = $clog2(CLAIM_WAIT + 1);

  function automatic logic cfg_hit(input logic [7:0] a);
    return a <= CFG_NAME_HI;
  endfunction

  cni_tx_if tq ();

  cni_state_t state;
  cni_state_t next_state;
  logic [7:0] cfg_sa;
  logic [7:0] claim_sa;
  logic [7:0] next_claim_sa;
  logic [2:0] ecu_inst;
  logic [20:0] ident;
  logic [TW-1:0] wait_cnt;
  logic [63:0] name;
  logic [31:0] cfg_value;

  // ****************************************************************
  // Received frame decode
  // ****************************************************************
  wire [7:0] rx_pf = rx_id[23:16];
  wire [7:0] rx_ps = rx_id[15:8];
  wire [7:0] rx_sa = rx_id[7:0];
  wire for_us = rx_ps == claim_sa || rx_ps == DA_GLOBAL;
  wire rx_req = rx_valid && rx_pf == PF_REQUEST && for_us && rx_dlc >= DLC_REQUEST;
  wire req_soft_hit = rx_req && rx_data[23:0] == PGN_SOFT_ID; // [RQ8]
  wire req_claim_hit = rx_req && rx_data[23:0] == PGN_ADDR_CLAIM;
  wire rx_claim = rx_valid && rx_pf == PF_ADDR_CLAIM && rx_sa == claim_sa
    && rx_dlc == DLC_FULL;
  // Claims heard while ours is still queued go uncontested
  wire contending = state == ST_WAIT || state == ST_OK;
  // Lower identity value carries the higher priority
  wire we_lose = rx_claim && contending && rx_data < name; // [RQ7]
  wire we_win = rx_claim && contending && rx_data > name;
  wire give_up = we_lose && claim_sa == SA_MAX; // [RQ14]

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  wire sa_ok = cfg_wdata[31:8] == 24'h0 && cfg_wdata[7:0] <= SA_MAX; // [RQ6]
  wire sa_wr = cfg_wr && cfg_addr == CFG_SA && sa_ok; // [RQ10]
  wire sa_new = sa_wr && (cfg_wdata[7:0] != cfg_sa || state == ST_LOST); // [RQ1]
  wire ecu_wr = cfg_wr && cfg_addr == CFG_ECU_INST && cfg_wdata[31:3] == 29'h0;
  wire app_wr = cfg_wr && cfg_addr == CFG_APP_PGN && (cfg_wdata >> APP_PGN_N) == 32'h0;
  wire wr_ok = sa_wr || ecu_wr || app_wr;
  wire acc_ok = cfg_rd ? cfg_hit(cfg_addr) : wr_ok;
  wire rd_known = cfg_hit(cfg_addr);

  assign name = {NAME_AAC, NAME_IND_GROUP, NAME_VS_INST, NAME_VSYS, NAME_RSVD,
    FUNCTION_CODE, NAME_FUNC_INST, ecu_inst, MAKER_CODE, ident}; // [RQ2] [RQ3] [RQ4]

  assign cfg_value = !rd_known ? 32'h0 :
    cfg_addr == CFG_SA ? {24'h0, cfg_sa} :
    cfg_addr == CFG_ECU_INST ? {29'h0, ecu_inst} :
    cfg_addr == CFG_APP_PGN ? 32'(app_pgn_en) :
    cfg_addr == CFG_STATUS ? {20'h0, app_traffic_en, state, claim_sa} :
    cfg_addr == CFG_NAME_LO ? name[31:0] : name[63:32];

  assign tq.sa = claim_sa;

  // ****************************************************************
  // Address contention
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_BOOT: next_state = ST_SEND; // [RQ1]
      ST_SEND: next_state = tq.claim_sent ? ST_WAIT : ST_SEND;
      ST_WAIT: next_state = wait_cnt == '0 ? ST_OK : ST_WAIT;
      ST_OK: next_state = ST_OK;
      ST_LOST: next_state = ST_LOST;
      default: next_state = ST_BOOT;
    endcase
    if (sa_new)
    begin
      next_state = ST_SEND; // [RQ1]
    end
    else if (give_up)
    begin
      next_state = ST_LOST; // [RQ14]
    end
    else if (we_lose)
    begin
      next_state = ST_SEND; // [RQ7]
    end
  end

  assign next_claim_sa = sa_new ? cfg_wdata[7:0] :
    (we_lose && !give_up) ? claim_sa + 8'h01 : claim_sa; // [RQ7]

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_BOOT;
      claim_sa <= SA_DEFAULT; // [RQ5]
    end
    else
    begin
      state <= next_state;
      claim_sa <= next_claim_sa;
    end
  end

  // Silence window after our claim went out
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wait_cnt <= '0;
    else if (state == ST_SEND)
      wait_cnt <= TW'(CLAIM_WAIT - 1);
    else if (state == ST_WAIT && wait_cnt != '0)
      wait_cnt <= wait_cnt - TW'(1);
  end

  // Factory value is caught on the first edge after release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ident <= 21'h0;
    else if (state == ST_BOOT)
      ident <= factory_identity; // [RQ3]
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_sa <= SA_DEFAULT; // [RQ5]
      ecu_inst <= ECU_INST_DEFAULT; // [RQ2]
      app_pgn_en <= '0; // [RQ11]
    end
    else
    begin
      if (sa_wr)
        cfg_sa <= cfg_wdata[7:0]; // [RQ6]
      if (ecu_wr)
        ecu_inst <= cfg_wdata[2:0]; // [RQ4]
      if (app_wr)
        app_pgn_en <= cfg_wdata[APP_PGN_N-1:0]; // [RQ11]
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cfg_rdata <= 32'h0;
    else
      cfg_rdata <= cfg_rd ? cfg_value : 32'h0;
  end

  // ****************************************************************
  // Send requests
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tq.req_claim <= 1'b0;
      tq.req_cannot <= 1'b0;
      tq.req_soft <= 1'b0;
      tq.req_resp <= 1'b0;
      app_traffic_en <= 1'b0;
    end
    else
    begin
      // An address write outranks a lost contention in the same cycle
      tq.req_claim <= sa_new || (!give_up && (state == ST_BOOT || we_lose || we_win
        || (req_claim_hit && contending))); // [RQ1] [RQ7]
      tq.req_cannot <= !sa_new && (give_up
        || (req_claim_hit && state == ST_LOST)); // [RQ14]
      tq.req_soft <= req_soft_hit && state == ST_OK; // [RQ8]
      tq.req_resp <= cfg_wr || cfg_rd; // [RQ13]
      app_traffic_en <= next_state == ST_OK; // [RQ14]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tq.resp_dest <= 8'h00;
      tq.resp_status <= 8'h00;
      tq.resp_addr <= 8'h00;
      tq.resp_value <= 32'h0;
    end
    else if (cfg_wr || cfg_rd)
    begin
      tq.resp_dest <= cfg_src;
      tq.resp_status <= acc_ok ? MAP_OK : MAP_ERR; // [RQ13]
      tq.resp_addr <= cfg_addr;
      tq.resp_value <= cfg_rd ? cfg_value : cfg_wdata;
    end
  end

  // ****************************************************************
  // Frame builder
  // ****************************************************************
  cni_tx_framer #(
    .VER_LEN(VER_LEN),
    .VERSION(VERSION)
  ) u_framer (
    .clk(clk),
    .rstn(rstn),
    .tq(tq.frm),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_id(tx_id),
    .tx_dlc(tx_dlc),
    .tx_data(tx_data)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_new_sa;
    sa_new;
  endsequence
  sequence s_reclaim;
    tq.req_claim && state == ST_SEND && claim_sa == $past(cfg_wdata[7:0]);
  endsequence
  sequence s_lose_step;
    we_lose && !give_up && !sa_new;
  endsequence
  sequence s_next_addr;
    claim_sa == $past(claim_sa) + 8'h01 && state == ST_SEND ##0 tq.req_claim;
  endsequence

  boot_claim_a: assert property (state == ST_BOOT |=> tq.req_claim && state == ST_SEND) // [RQ1]
    else $error("no claim after power-up");
  sa_reclaim_a: assert property (s_new_sa |=> s_reclaim) // [RQ1]
    else $error("no claim after address change");
  name_default_a: assert property (name[63:48] == 16'h8000 && name[NAME_AAC_BIT]) // [RQ2]
    else $error("identity defaults wrong");
  ident_capture_a: assert property (state == ST_BOOT
    |=> name[NAME_ID_MSB:0] == $past(factory_identity) ##1 $stable(ident)) // [RQ3]
    else $error("factory identity not captured");
  ecu_inst_a: assert property (ecu_wr
    |=> name[NAME_ECU_MSB:NAME_ECU_LSB] == $past(cfg_wdata[2:0])) // [RQ4]
    else $error("instance field not updated");
  sa_default_a: assert property (state == ST_BOOT |-> cfg_sa == 8'h80 && claim_sa == 8'h80) // [RQ5]
    else $error("default address not 0x80");
  sa_range_a: assert property (cfg_wr && cfg_addr == CFG_SA && !sa_ok
    |=> $stable(cfg_sa) && claim_sa <= 8'd253) // [RQ6]
    else $error("out of range address accepted");
  lose_step_a: assert property (s_lose_step |=> s_next_addr) // [RQ7]
    else $error("lost contention did not step address");
  soft_cause_a: assert property (tq.req_soft |-> $past(req_soft_hit) && $past(state) == ST_OK) // [RQ8]
    else $error("software id sent unrequested");
  app_default_a: assert property (state == ST_BOOT |-> app_pgn_en == '0) // [RQ11]
    else $error("application groups enabled at reset");
  resp_a: assert property ((cfg_wr || cfg_rd) |=> tq.req_resp
    && tq.resp_dest == $past(cfg_src)) // [RQ13]
    else $error("memory access left unanswered");
  give_up_a: assert property (give_up && !sa_new
    |=> state == ST_LOST && tq.req_cannot ##1 !app_traffic_en [*3]) // [RQ14]
    else $error("cannot-claim not handled");
  traffic_ok_a: assert property (app_traffic_en |-> state == ST_OK) // [RQ14]
    else $error("traffic enabled without an address");
  cannot_req_a: assert property (req_claim_hit && state == ST_LOST && !sa_new // [RQ14]
    |=> tq.req_cannot)
    else $error("claim request in lost state unanswered");
  claim_req_a: assert property (req_claim_hit && contending && !give_up // [RQ7]
    |=> tq.req_claim)
    else $error("claim request not answered");
  wait_len_a: assert property (state == ST_SEND ##1 state == ST_WAIT // [RQ7]
    |-> wait_cnt == TW'(CLAIM_WAIT - 1))
    else $error("contention window length wrong");

endmodule
`default_nettype wire

// ---- rtl/cni_identity_dummy_guard.sv ----
// Intentionally empty compile unit guard
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- tb/cni_far_node.sv ----
// Far-side CAN node model: frame sink with stalls and frame source
`timescale 1ns/1ps
`default_nettype none
module cni_far_node
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Frames from the node
  input wire logic tx_valid,
  input wire logic [28:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  output logic tx_ready,
  // Frames to the node
  output logic rx_valid,
  output logic [28:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data
);
  int stall = 0;
  int wait_cnt = 0;
  logic [28:0] q_id[$];
  logic [3:0] q_dlc[$];
  logic [63:0] q_data[$];

  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id = 29'h0;
    rx_dlc = 4'h0;
    rx_data = 64'h0;
  end

  // ****************************************************************
  // Sink: ready held back for stall + 1 cycles, as a busy bus would
  // ****************************************************************
  always @(posedge clk or negedge rstn)
    if (!rstn)
      tx_ready <= 1'b0;
    else if (tx_valid && tx_ready)
    begin
      q_id.push_back(tx_id);
      q_dlc.push_back(tx_dlc);
      q_data.push_back(tx_data);
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end
    else if (tx_valid)
    begin
      tx_ready <= (wait_cnt >= stall);
      wait_cnt <= wait_cnt + 1;
    end

  // ****************************************************************
  // Source: one-cycle frame, lines scrambled once released
  // ****************************************************************
  task automatic send_rx(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_dlc <= dlc;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_dlc <= ~dlc;
    rx_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_cni_identity.sv ----
// Self-checking bench for the network identity block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_cni_identity
  import cni_pkg::*;
;
  // Short contention wait keeps the run small
  localparam int CW = 20;
  localparam logic [20:0] FID = 21'h15a5c3;
  localparam logic [7:0] TOOL = 8'h2b;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [31:0] cfg_rdata;
  logic rx_valid;
  logic [28:0] rx_id;
  logic [3:0] rx_dlc;
  logic [63:0] rx_data;
  logic tx_ready;
  logic tx_valid;
  logic [28:0] tx_id;
  logic [3:0] tx_dlc;
  logic [63:0] tx_data;
  logic app_traffic_en;
  logic [7:0] app_pgn_en;
  logic [31:0] rd;
  logic [28:0] fid;
  logic [3:0] fdlc;
  logic [63:0] fdat;
  int err_total = 0;
  int cmp_count = 0;

  always #2.5 clk = ~clk;

  cni_identity #(.CLAIM_WAIT(CW)) DUT (.clk(clk), .rstn(rstn), .factory_identity(FID),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_src(TOOL), .cfg_rdata(cfg_rdata), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .app_traffic_en(app_traffic_en),
    .app_pgn_en(app_pgn_en));

  cni_far_node far (.clk(clk), .rstn(rstn), .tx_valid(tx_valid), .tx_id(tx_id),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data));

  // ****************************************************************
  // Frame and access helpers
  // ****************************************************************
  function automatic logic [28:0] idf(input logic [7:0] pf, ps, sa);
    return {3'h6, 2'b00, pf, ps, sa};
  endfunction

  // Frames may arrive out of order, so pick by format
  task automatic take(input logic [7:0] pf);
    int k;
    k = -1;
    for (int n = 0; n < 300 && k < 0; n++)
    begin
      @(posedge clk);
      #1;
      foreach (far.q_id[i])
        if (k < 0 && far.q_id[i][23:16] === pf)
          k = i;
    end
    `CHK(k >= 0, 1'b1)
    if (k >= 0)
    begin
      fid = far.q_id[k];
      fdlc = far.q_dlc[k];
      fdat = far.q_data[k];
      far.q_id.delete(k);
      far.q_dlc.delete(k);
      far.q_data.delete(k);
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    take(PF_MAP_RESP);
    `CHK(fid[15:8], TOOL)
  endtask

  task automatic cfg_read(input logic [7:0] a);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 rd = cfg_rdata;
    take(PF_MAP_RESP);
    `CHK(fid[15:8], TOOL)
  endtask

  task automatic claim_at(input logic [7:0] sa);
    take(PF_ADDR_CLAIM);
    `CHK(fid, idf(8'hee, 8'hff, sa))
    repeat (CW + 10) @(posedge clk);
    #1;
  endtask

  task automatic end_sim;
    $display("mismatches=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    claim_at(8'h80);
    `CHK(fdlc, 4'h8)
    `CHK(app_traffic_en, 1'b1)
    cfg_read(CFG_STATUS);
    `CHK(rd[11:0], 12'ha80)
    cfg_read(CFG_SA);
    `CHK(rd, 32'h80)
    cfg_read(CFG_APP_PGN);
    `CHK(rd, 32'h0)
    `CHK(app_pgn_en, 8'h00)
    cfg_write(CFG_APP_PGN, 32'h5);
    `CHK(fdat, 64'h00000005ffff0200)
    `CHK(app_pgn_en, 8'h05)
    cfg_read(CFG_NAME_LO);
    `CHK(rd[20:0], FID)
    cfg_read(CFG_NAME_HI);
    `CHK(rd[31:17], 15'h4000)
    `CHK(rd[2:0], 3'h0)
    cfg_write(CFG_ECU_INST, 32'h5);
    cfg_write(CFG_ECU_INST, 32'h8);
    `CHK(fdat[7:0], 8'h01)
    cfg_read(CFG_NAME_HI);
    `CHK(rd[2:0], 3'h5)
    cfg_read(8'h40);
    `CHK(fdat[7:0], 8'h01)
    `CHK(rd, 32'h0)
    // Silence first: the software id must not appear unasked
    repeat (200) @(posedge clk);
    `CHK(far.q_id.size(), 0)
    far.stall = 3;
    far.send_rx(idf(PF_REQUEST, 8'hff, TOOL), 4'h3, 64'h0000_0000_0000_feda);
    take(PF_SOFT_ID);
    far.stall = 0;
    `CHK(fid, idf(8'hfe, 8'hda, 8'h80))
    `CHK(fdlc, 4'h6)
    `CHK(fdat[47:0], 48'h2a30302e3101)
    cfg_write(CFG_SA, 32'hfe);
    `CHK(fdat[7:0], 8'h01)
    cfg_read(CFG_SA);
    `CHK(rd, 32'h80)
    cfg_write(CFG_SA, 32'h90);
    claim_at(8'h90);
    far.send_rx(idf(8'hee, 8'hff, 8'h90), 4'h8, 64'h0);
    claim_at(8'h91);
    far.send_rx(idf(8'hee, 8'hff, 8'h91), 4'h8, {64{1'b1}});
    claim_at(8'h91);
    far.send_rx(idf(PF_REQUEST, 8'hff, TOOL), 4'h3, 64'h0000_0000_0000_ee00);
    claim_at(8'h91);
    cfg_write(CFG_SA, 32'hfd);
    claim_at(8'hfd);
    far.send_rx(idf(8'hee, 8'hff, 8'hfd), 4'h8, 64'h0);
    claim_at(8'hfe);
    `CHK(app_traffic_en, 1'b0)
    cfg_read(CFG_STATUS);
    `CHK(rd[11:8], 4'h6)
    far.send_rx(idf(PF_REQUEST, 8'hff, TOOL), 4'h3, 64'h0000_0000_0000_ee00);
    claim_at(8'hfe);
    // Second power-up must claim the default address again
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    claim_at(8'h80);
    `CHK(app_traffic_en, 1'b1)
    `CHK(app_pgn_en, 8'h00)
    end_sim;
  end

  // Whole run is several hundred cycles
  initial
  begin
    #60us;
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire
